//--- logic/asrc_top.v
// power-state and reset controller for a multichannel converter
`include "asrc_map.vh"
`timescale 1ns/100ps

module asrc_top
(
  input  wire mclk,                  // 200 MHz block clock
  input  wire rst,                   // synchronous reset, high
  input  wire reset_pin,             // device reset pin, high active, asynchronous
  input  wire conversion_start,      // conversion start pin, asynchronous
  input  wire sclk,                  // serial clock pin, asynchronous
  input  wire serial_bus_disable,    // bus disable pin, high disables, asynchronous
  output reg  busy_ff,               // conversion in progress
  output reg  core_pd_ff,            // converter core powered down whenever not converting (reset, acquisition, nap or sleep)
  output reg  all_pd_ff,             // everything but standby powered down
  output reg  sleep_ff,              // sleep state indicator
  output reg  sdo_oe_ff,             // serial data output enable, high drives
  output reg  clear_ff,              // clear to output register and sequencer memory
  output reg  abort_ff,              // one-cycle pulse aborting the core conversion
  output reg  conv_go_ff             // one-cycle pulse starting a core conversion
);

  wire                  rst_pin_s;
  wire                  cnv_s;
  wire                  sck_s;
  wire                  rdl_s;
  reg                   cnv_d_ff;
  reg                   sck_d_ff;
  reg  [2:0]            state_ff;
  reg  [2:0]            nxt_state;
  reg  [`ASRC_CNT_W-1:0] cnt_ff;
  reg  [`ASRC_CNT_W-1:0] nxt_cnt;
  reg                   sck_seen_ff;
  reg                   first_done_ff;
  reg                   sleep_req_ff;
  wire                  cnv_rise;
  wire                  sck_rise;

  // counts are worked out wide, then cut to the counter width on purpose
  localparam integer           CONV_LAST_I = `ASRC_CONV_CYCLES - 1;
  localparam integer           ACQ_LAST_I  = `ASRC_ACQ_CYCLES - 1;
  localparam [`ASRC_CNT_W-1:0] CONV_LAST   = CONV_LAST_I[`ASRC_CNT_W-1:0];
  localparam [`ASRC_CNT_W-1:0] ACQ_LAST    = ACQ_LAST_I[`ASRC_CNT_W-1:0];

  // power states
  localparam [2:0]             ST_RESET    = `ASRC_ST_RESET;
  localparam [2:0]             ST_ACQ      = `ASRC_ST_ACQ;
  localparam [2:0]             ST_CONV     = `ASRC_ST_CONV;
  localparam [2:0]             ST_SLEEP    = `ASRC_ST_SLEEP;
  localparam [2:0]             ST_READY    = `ASRC_ST_READY;

  wire [3:0]                   pin_raw;
  wire [3:0]                   pin_s;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // bit order: reset pin, start, serial clock, bus disable
  assign pin_raw = {serial_bus_disable, sclk, conversion_start, reset_pin};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_sync
      asrc_sync u_sync
      (
        .mclk    (mclk),
        .rst     (rst),
        .din     (pin_raw[gi]),
        .dout_ff (pin_s[gi])
      );
    end
  endgenerate

  assign rst_pin_s = pin_s[0];
  assign cnv_s     = pin_s[1];
  assign sck_s     = pin_s[2];
  assign rdl_s     = pin_s[3];

  // edge detection on the synchronised copies only
  always @(posedge mclk)
  begin
    if (rst)
    begin
      cnv_d_ff <= 1'B0;
      sck_d_ff <= 1'B0;
    end
    else
    begin
      cnv_d_ff <= cnv_s;
      sck_d_ff <= sck_s;
    end
  end

  assign cnv_rise = cnv_s & ~cnv_d_ff;
  assign sck_rise = sck_s & ~sck_d_ff;

  // ----------------------------------------
  // power state machine
  // ----------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    case (state_ff)
      ST_RESET:
      begin
        nxt_cnt = {`ASRC_CNT_W{1'B0}};
        if (!rst_pin_s)
          nxt_state = ST_ACQ;
      end
      ST_ACQ:
      begin
        // starts during the acquisition window after reset are dropped
        if (cnt_ff == ACQ_LAST)
          nxt_state = ST_READY;
        else
          nxt_cnt = cnt_ff + 1'B1;
      end
      ST_READY:
      begin
        nxt_cnt = {`ASRC_CNT_W{1'B0}};
        if (cnv_rise)
          nxt_state = ST_CONV;
      end
      ST_CONV:
      begin
        if (cnt_ff == CONV_LAST)
        begin
          nxt_cnt = {`ASRC_CNT_W{1'B0}};
          // busy falls here: sleep if requested, else nap in ready
          if (sleep_req_ff)
            nxt_state = ST_SLEEP;
          else
            nxt_state = ST_READY;
        end
        else
          nxt_cnt = cnt_ff + 1'B1;
      end
      ST_SLEEP:
      begin
        nxt_cnt = {`ASRC_CNT_W{1'B0}};
        // wake-up delay is the host's to honour; no lockout here
        if (sck_rise)
          nxt_state = ST_READY;
      end
      default:
        nxt_state = ST_RESET;
    endcase
    // reset pin overrides everything, aborting any conversion
    if (rst_pin_s)
    begin
      nxt_state = ST_RESET;
      nxt_cnt   = {`ASRC_CNT_W{1'B0}};
    end
  end

  always @(posedge mclk)
  begin
    if (rst)
    begin
      state_ff <= ST_RESET;
      cnt_ff   <= {`ASRC_CNT_W{1'B0}};
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  // ----------------------------------------
  // sleep request detection
  // ----------------------------------------
  // a start during a conversion still counts toward a sleep request
  always @(posedge mclk)
  begin
    if (rst || rst_pin_s)
    begin
      sck_seen_ff   <= 1'B0;
      first_done_ff <= 1'B0;
      sleep_req_ff  <= 1'B0;
    end
    else
    begin
      if (cnv_rise)
      begin
        // a start with no clock since the previous one requests sleep
        // a clock edge in the same cycle separates the starts, so no request
        if (first_done_ff && !sck_seen_ff && !sck_rise)
          sleep_req_ff <= 1'B1;
        first_done_ff <= 1'B1;
        sck_seen_ff   <= sck_rise;                               // edge in same cycle still counts
      end
      else if (sck_rise)
        sck_seen_ff <= 1'B1;
      if (state_ff == ST_SLEEP && sck_rise)
      begin
        sleep_req_ff  <= 1'B0;
        first_done_ff <= 1'B0;
      end
      else if (nxt_state == ST_SLEEP)
        first_done_ff <= 1'B0;
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  // clear only follows the reset pin; sleep never touches sequencer state
  always @(posedge mclk)
  begin
    if (rst)
    begin
      busy_ff    <= 1'B0;
      core_pd_ff <= 1'B1;
      all_pd_ff  <= 1'B0;
      sleep_ff   <= 1'B0;
      sdo_oe_ff  <= 1'B0;
      clear_ff   <= 1'B1;
      abort_ff   <= 1'B0;
      conv_go_ff <= 1'B0;
    end
    else
    begin
      busy_ff    <= (nxt_state == ST_CONV);
      core_pd_ff <= (nxt_state != ST_CONV);
      all_pd_ff  <= (nxt_state == ST_SLEEP);
      sleep_ff   <= (nxt_state == ST_SLEEP);
      sdo_oe_ff  <= ~rst_pin_s & ~rdl_s;
      clear_ff   <= rst_pin_s;
      abort_ff   <= rst_pin_s & (state_ff == ST_CONV);
      conv_go_ff <= (state_ff != ST_CONV) && (nxt_state == ST_CONV);
    end
  end

endmodule

//--- logic/asrc_map.vh
// timing constants and encodings for the sleep and reset controller
`ifndef ASRC_MAP_VH
`define ASRC_MAP_VH

// ----------------------------------------
// timing
// ----------------------------------------
`define ASRC_CLK_PERIOD_NS   5
`define ASRC_CONV_TIME_NS    500
`define ASRC_CONV_CYCLES     ((`ASRC_CONV_TIME_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_ACQ_TIME_NS     100
`define ASRC_ACQ_CYCLES      ((`ASRC_ACQ_TIME_NS + `ASRC_CLK_PERIOD_NS - 1) / `ASRC_CLK_PERIOD_NS)
`define ASRC_CNT_W           8

// ----------------------------------------
// power states
// ----------------------------------------
`define ASRC_ST_RESET        3'H0
`define ASRC_ST_ACQ          3'H1
`define ASRC_ST_CONV         3'H2
`define ASRC_ST_SLEEP        3'H3
`define ASRC_ST_READY        3'H4

`endif

//--- logic/asrc_sync.v
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps

module asrc_sync
(
  input  wire mclk,    // block clock
  input  wire rst,     // synchronous reset, high
  input  wire din,     // asynchronous pin level
  output reg  dout_ff  // synchronised level
);

  reg meta_ff;

  // ----------------------------------------
  // synchroniser
  // ----------------------------------------
  // the first flop feeds only the second, so no logic sees a metastable value
  always @(posedge mclk)
  begin
    if (rst)
    begin
      meta_ff <= 1'B0;
      dout_ff <= 1'B0;
    end
    else
    begin
      meta_ff <= din;
      dout_ff <= meta_ff;
    end
  end

endmodule

//--- test/asrc_top_properties.sv
// concurrent checks on the sleep and reset controller ports
`timescale 1ns/100ps
module asrc_top_properties
(
  input wire mclk,
  input wire rst,
  input wire reset_pin,
  input wire sclk,
  input wire serial_bus_disable,
  input wire busy_ff,
  input wire core_pd_ff,
  input wire all_pd_ff,
  input wire sleep_ff,
  input wire sdo_oe_ff,
  input wire clear_ff,
  input wire abort_ff,
  input wire conv_go_ff
);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // twenty idle cycles once the device reset lets go
  sequence s_acq;
    !busy_ff[*8] ##1 !busy_ff[*8] ##1 !busy_ff[*4];
  endsequence
  AST_GO: assert property ($rose(busy_ff) |-> conv_go_ff && !core_pd_ff)
    else $error("busy rose without start pulse");
  AST_LEN: assert property ($fell(busy_ff) && !clear_ff |-> $past(busy_ff, 100) && !$past(busy_ff, 101))
    else $error("conversion length wrong");
  AST_NAP: assert property (core_pd_ff == !busy_ff)
    else $error("core power-down wrong");
  AST_SLP: assert property ($rose(all_pd_ff) |-> $fell(busy_ff) && sleep_ff)
    else $error("sleep entered off busy fall");
  AST_WAKE: assert property (sleep_ff && $rose(sclk) |-> ##[1:6] !sleep_ff)
    else $error("no wake on serial clock");
  AST_BUS: assert property ((reset_pin || serial_bus_disable)[*4] |-> !sdo_oe_ff)
    else $error("serial bus driven while off");
  AST_CLR: assert property (reset_pin[*4] |-> clear_ff && !busy_ff && !conv_go_ff)
    else $error("reset did not hold");
  AST_ABT: assert property (busy_ff && $rose(reset_pin) |-> ##[1:4] abort_ff)
    else $error("conversion not aborted");
  AST_ACQ: assert property ($fell(clear_ff) |-> s_acq)
    else $error("start before acquisition");
endmodule

bind asrc_top asrc_top_properties u_prop
(
  .mclk(mclk), .rst(rst), .reset_pin(reset_pin), .sclk(sclk),
  .serial_bus_disable(serial_bus_disable), .busy_ff(busy_ff), .core_pd_ff(core_pd_ff),
  .all_pd_ff(all_pd_ff), .sleep_ff(sleep_ff), .sdo_oe_ff(sdo_oe_ff), .clear_ff(clear_ff),
  .abort_ff(abort_ff), .conv_go_ff(conv_go_ff)
);

//--- test/asrc_host.sv
// host pin driver facing the sleep and reset controller
`timescale 1ns/100ps
module asrc_host
(
  output logic conversion_start,   // start pin
  output logic sclk,               // link clock, still between frames
  output logic serial_bus_disable, // bus off when high
  output logic reset_pin           // device reset
);
  // all pins quiet at time zero
  initial {conversion_start, sclk, serial_bus_disable, reset_pin} = 4'H0;
  // pulse held 20 ns so the synchroniser cannot miss it
  task start;
    conversion_start = 1'b1;
    #20 conversion_start = 1'b0;
  endtask
  // one 160 ns link clock frame, then the wake-up delay
  task wake;
    sclk = 1'b1;
    #80 sclk = 1'b0;
    #80;
    #100;
  endtask
  // host waits out acquisition before the next start
  task release_rst;
    reset_pin = 1'b0;
    #150;
  endtask
endmodule

//--- test/asrc_top_bench.sv
// self-checking bench for the sleep and reset controller
`timescale 1ns/100ps
module asrc_top_bench;
  logic   mclk, rst, cs, sck, dis, rp;
  logic   busy, cpd, apd, slp, oe, clr, abt, go;
  integer errors, checks, seed, n;
  // model state: start pulses since the last serial clock rise, request, sleep
  integer gos = 0;
  integer m_pend = 0;
  integer m_req = 0;
  integer m_asleep = 0;
  // ----------------------------------------
  // clock, parts and helpers
  // ----------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  asrc_host u_host (.conversion_start(cs), .sclk(sck), .serial_bus_disable(dis), .reset_pin(rp));
  asrc_top u_dut (.mclk(mclk), .rst(rst), .reset_pin(rp), .conversion_start(cs), .sclk(sck),
    .serial_bus_disable(dis), .busy_ff(busy), .core_pd_ff(cpd), .all_pd_ff(apd), .sleep_ff(slp),
    .sdo_oe_ff(oe), .clear_ff(clr), .abort_ff(abt), .conv_go_ff(go));
  task wrap_up;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic got, input logic exp);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH %0t got %b expected %b", $time, got, exp);
    end
  endtask
  // bounded wait for busy, counting cycles; a hang ends the run
  task till(input logic v, output integer c);
    c = 0;
    while (busy !== v && c < 300)
    begin
      @(negedge mclk);
      c++;
    end
    if (c == 300)
    begin
      errors++;
      wrap_up;
    end
  endtask
  // ----------------------------------------
  // behavioural model of the sleep request
  // ----------------------------------------
  // two starts with no serial clock rise between them ask for sleep
  always @(posedge cs)
    if (rp !== 1'b1)
    begin
      m_pend = m_pend + 1;
      if (m_pend >= 2)
        m_req = 1;
    end
  // a serial clock rise separates starts and wakes a sleeping device
  always @(posedge sck)
  begin
    m_pend = 0;
    if (m_asleep != 0)
    begin
      m_asleep = 0;
      m_req = 0;
    end
  end
  // the reset pin forgets every pending request
  always @(posedge rp)
  begin
    m_pend = 0;
    m_req = 0;
    m_asleep = 0;
  end
  // sleep begins where busy ends a conversion after a request
  always @(negedge busy)
    if (m_req != 0 && rp !== 1'b1)
    begin
      m_asleep = 1;
      m_pend = 0;
    end
  // count conversion start pulses away from the edge that launches them
  always @(negedge mclk)
    if (go === 1'b1)
      gos = gos + 1;
  // main sequence; model length of a conversion is 100 cycles
  initial
  begin
    errors = 0; checks = 0; seed = 32'h2B0F7336; rst = 1'b1;
    repeat (4) @(negedge mclk);
    rst = 1'b0;
    repeat (30) @(negedge mclk);
    u_host.start; till(1, n); till(0, n);
    chk(n >= 97 && n <= 100, 1);
    chk(cpd, 1);
    $display("test 1 done");
    repeat (30) @(negedge mclk);
    u_host.start; repeat (10) @(negedge mclk); u_host.start;
    till(0, n); @(negedge mclk);
    chk(slp & apd, 1);
    chk(slp, m_asleep != 0);
    chk(clr, 0);
    repeat (4)
    begin
      n = $random(seed); u_host.serial_bus_disable = n[0]; repeat (6) @(negedge mclk);
      chk(oe, !n[0]);
    end
    u_host.serial_bus_disable = 1'b0; u_host.wake;
    chk(slp, 0);
    chk(slp, m_asleep != 0);
    $display("test 2 done");
    u_host.start; u_host.wake; u_host.start; till(0, n); @(negedge mclk);
    chk(slp, 0);
    chk(slp, m_asleep != 0);
    $display("test 3 done");
    repeat (30) @(negedge mclk);
    u_host.start; repeat (20) @(negedge mclk);
    u_host.reset_pin = 1'b1; repeat (3) @(negedge mclk);
    chk(abt, 1);
    repeat (3) @(negedge mclk);
    chk(busy | !clr | oe, 0);
    u_host.start; repeat (6) @(negedge mclk);
    chk(busy, 0);
    u_host.release_rst; u_host.start; till(1, n);
    chk(busy, 1);
    till(0, n);
    chk(gos == 5, 1);
    $display("test 4 done");
    wrap_up;
  end
endmodule
